// >>> hw/lcs_cycle_timer.v
// Cycle timer: offset counter and cycle count with internal or external cycle source
`timescale 1ns/1ps
`default_nettype none
`include "lcs_map.vh"
module lcs_cycle_timer #(
    parameter OFFSET_W = `LCS_CYC_OFFSET_W,
    parameter COUNT_W = `LCS_CYC_COUNT_W,
    parameter [OFFSET_W-1:0] OFFSET_WRAP = `LCS_CYC_OFFSET_WRAP
) (
    input wire clk,
    input wire resetn,
    input wire timer_run,
    input wire ext_source_sel,
    input wire ext_edge,
    output reg [OFFSET_W-1:0] cycle_offset_reg,
    output reg [COUNT_W-1:0] cycle_count_reg,
    output reg count_inc_reg
);
    localparam [OFFSET_W-1:0] OFFSET_LAST = OFFSET_WRAP - {{(OFFSET_W-1){1'b0}}, 1'b1};
    wire offset_wrap;
    wire ext_tick;
    wire count_step;

    assign offset_wrap = timer_run && (cycle_offset_reg == OFFSET_LAST);
    assign ext_tick = ext_source_sel && ext_edge;
    assign count_step = ext_tick || (!ext_source_sel && offset_wrap);

    always @(posedge clk) begin
        if (!resetn) begin
            cycle_offset_reg <= {OFFSET_W{1'b0}};
            cycle_count_reg <= {COUNT_W{1'b0}};
            count_inc_reg <= 1'b0;
        end else begin
            if (ext_tick) begin
                cycle_offset_reg <= {OFFSET_W{1'b0}}; // RULE1
            end else if (offset_wrap) begin
                cycle_offset_reg <= {OFFSET_W{1'b0}};
            end else if (timer_run) begin
                cycle_offset_reg <= cycle_offset_reg + {{(OFFSET_W-1){1'b0}}, 1'b1}; // RULE3
            end
            if (count_step) begin
                cycle_count_reg <= cycle_count_reg + {{(COUNT_W-1){1'b0}}, 1'b1}; // RULE1 RULE2
            end
            count_inc_reg <= count_step;
        end
    end
endmodule // lcs_cycle_timer
`default_nettype wire

// >>> hw/lcs_link_regs.v
// Link control, cycle timer and link interrupt acknowledge register bank
// Function
// RULE1 - With the external cycle source selected, each rising edge of the cycle pin bumps the count and clears the offset.
// RULE2 - With the internal source selected, the count bumps only when the offset wraps.
// RULE3 - The offset counter advances only while the timer run bit is set and holds otherwise; code clears it on an external edge even when stopped.
// RULE4 - A read-only bit reads one while the transmitter is idle and ready.
// RULE5 - A read-only root bit shows root status and is refreshed when self identification ends.
// RULE6 - A read-only bit gives the next busy acknowledge type, 0 for A and 1 for B.
// RULE7 - Bits 3 to 0 hold the last acknowledge code for a packet sent from the async transmit FIFO.
// RULE8 - Writing one to a set acknowledge bit clears it.
// RULE9 - Writing one to a clear bit, or zero to any bit, leaves the acknowledge register unchanged.
// RULE10 - An enable register mirrors the acknowledge register bit for bit.
// RULE11 - An interrupt is raised for any acknowledge flag whose enable bit is set.
// RULE12 - The command reset flag sets on a write request to the bus reset start register.
// RULE13 - The subaction gap flag sets when the bus has been idle for a subaction gap.
// RULE14 - The arbitration reset gap flag sets when the bus has been idle for an arbitration reset gap.
// RULE15 - With cycle master enabled and this node root, a cycle start is requested on each count increment.
// RULE16 - Acknowledge flags clear on reset and stay set until software clears them.
`timescale 1ns/1ps
`default_nettype none
`include "lcs_map.vh"
module lcs_link_regs #(
    parameter ADDR_W = `LCS_ADDR_W,
    parameter OFFSET_W = `LCS_CYC_OFFSET_W,
    parameter COUNT_W = `LCS_CYC_COUNT_W,
    parameter [OFFSET_W-1:0] OFFSET_WRAP = `LCS_CYC_OFFSET_WRAP
) (
    input wire clk,
    input wire resetn,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire ext_cycle_pulse_in,
    input wire xmit_idle_in,
    input wire selfid_done,
    input wire selfid_root,
    input wire busy_phase_in,
    input wire async_ack_valid,
    input wire [3:0] async_ack_code,
    input wire reset_start_write,
    input wire subaction_gap_seen,
    input wire arb_reset_gap_seen,
    output reg link_irq,
    output reg cycle_start_req,
    output wire [OFFSET_W-1:0] cycle_offset,
    output wire [COUNT_W-1:0] cycle_count
);
    // Address decode shared by read and write paths
    function addr_hit;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-1:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // Control bits written by software
    reg cycle_master_enable_reg;
    reg ext_cycle_source_sel_reg;
    reg cycle_timer_run_reg;

    // Status captured from link logic
    reg xmit_idle_flag_reg;
    reg root_reg;
    reg next_busy_phase_reg;
    reg [3:0] last_async_tx_ack_reg;

    // Interrupt acknowledge and enable
    reg [31:0] link_irq_ack_reg;
    reg [31:0] link_irq_ack_next;
    reg [31:0] link_irq_enable_reg;
    reg [31:0] irq_event;

    // Cycle pin synchroniser and edge detect
    wire cycle_pin_sync;
    reg cycle_pin_prev_reg;
    wire cycle_pin_rise;

    wire count_inc;
    wire wr_ctrl;
    wire wr_ack;
    wire wr_en;
    wire [31:0] ctrl_rd;
    wire [31:0] time_rd;
    reg [31:0] rdata_next;

    assign wr_ctrl = reg_wr && addr_hit(reg_addr, `LCS_OFF_LINK_CTRL);
    assign wr_ack = reg_wr && addr_hit(reg_addr, `LCS_OFF_IRQ_ACK);
    assign wr_en = reg_wr && addr_hit(reg_addr, `LCS_OFF_IRQ_EN);

    lcs_sync #(
        .WIDTH(1)
    ) u_cycle_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(ext_cycle_pulse_in),
        .sync_out(cycle_pin_sync)
    );

    always @(posedge clk) begin
        if (!resetn) begin
            cycle_pin_prev_reg <= 1'b0;
        end else begin
            cycle_pin_prev_reg <= cycle_pin_sync;
        end
    end

    assign cycle_pin_rise = cycle_pin_sync && !cycle_pin_prev_reg; // RULE1

    lcs_cycle_timer #(
        .OFFSET_W(OFFSET_W),
        .COUNT_W(COUNT_W),
        .OFFSET_WRAP(OFFSET_WRAP)
    ) u_cycle_timer (
        .clk(clk),
        .resetn(resetn),
        .timer_run(cycle_timer_run_reg),
        .ext_source_sel(ext_cycle_source_sel_reg),
        .ext_edge(cycle_pin_rise),
        .cycle_offset_reg(cycle_offset),
        .cycle_count_reg(cycle_count),
        .count_inc_reg(count_inc)
    );

    // Software control bits of the link control register
    always @(posedge clk) begin
        if (!resetn) begin
            cycle_master_enable_reg <= 1'b0;
            ext_cycle_source_sel_reg <= 1'b0;
            cycle_timer_run_reg <= 1'b0;
        end else if (wr_ctrl) begin
            cycle_master_enable_reg <= reg_wdata[`LCS_CTRL_MASTER_BIT];
            ext_cycle_source_sel_reg <= reg_wdata[`LCS_CTRL_EXT_SRC_BIT]; // RULE1 RULE2
            cycle_timer_run_reg <= reg_wdata[`LCS_CTRL_TIMER_RUN_BIT]; // RULE3
        end
    end

    // Read-only status captured from the link logic
    always @(posedge clk) begin
        if (!resetn) begin
            xmit_idle_flag_reg <= 1'b0;
            root_reg <= 1'b0;
            next_busy_phase_reg <= 1'b0;
            last_async_tx_ack_reg <= `LCS_CTRL_ACK_RESET;
        end else begin
            xmit_idle_flag_reg <= xmit_idle_in; // RULE4
            next_busy_phase_reg <= busy_phase_in; // RULE6
            if (selfid_done) begin
                root_reg <= selfid_root; // RULE5
            end
            if (async_ack_valid) begin
                last_async_tx_ack_reg <= async_ack_code; // RULE7
            end
        end
    end

    // Cycle start request on count increment while master and root
    always @(posedge clk) begin
        if (!resetn) begin
            cycle_start_req <= 1'b0;
        end else begin
            cycle_start_req <= count_inc && cycle_master_enable_reg && root_reg; // RULE15
        end
    end

    // Events that set acknowledge flags
    always @* begin
        irq_event = 32'h0000_0000;
        irq_event[`LCS_IRQ_CMD_RESET_BIT] = reset_start_write; // RULE12
        irq_event[`LCS_IRQ_SUBACTION_GAP_BIT] = subaction_gap_seen; // RULE13
        irq_event[`LCS_IRQ_ARB_RESET_GAP_BIT] = arb_reset_gap_seen; // RULE14
    end

    // Write one to clear; a new event in the same cycle wins
    always @* begin
        link_irq_ack_next = link_irq_ack_reg;
        if (wr_ack) begin
            link_irq_ack_next = link_irq_ack_reg & ~reg_wdata; // RULE8 RULE9
        end
        link_irq_ack_next = (link_irq_ack_next | irq_event) & `LCS_IRQ_MASK; // RULE16
    end

    always @(posedge clk) begin
        if (!resetn) begin
            link_irq_ack_reg <= `LCS_IRQ_RESET; // RULE16
        end else begin
            link_irq_ack_reg <= link_irq_ack_next;
        end
    end

    // Enable register with the same layout as the acknowledge register
    always @(posedge clk) begin
        if (!resetn) begin
            link_irq_enable_reg <= `LCS_IRQ_RESET;
        end else if (wr_en) begin
            link_irq_enable_reg <= reg_wdata & `LCS_IRQ_MASK; // RULE10
        end
    end

    // Interrupt output
    always @(posedge clk) begin
        if (!resetn) begin
            link_irq <= 1'b0;
        end else begin
            link_irq <= |(link_irq_ack_next & link_irq_enable_reg); // RULE11
        end
    end

    // Read data assembly
    assign ctrl_rd = {20'h00000,
                      cycle_master_enable_reg,
                      ext_cycle_source_sel_reg,
                      cycle_timer_run_reg,
                      2'b00,
                      xmit_idle_flag_reg,
                      root_reg,
                      next_busy_phase_reg,
                      last_async_tx_ack_reg};

    assign time_rd = {{(32 - COUNT_W - OFFSET_W){1'b0}}, cycle_count, cycle_offset};

    always @* begin
        rdata_next = 32'h0000_0000;
        if (addr_hit(reg_addr, `LCS_OFF_LINK_CTRL)) begin
            rdata_next = ctrl_rd; // RULE4 RULE5 RULE6 RULE7
        end else if (addr_hit(reg_addr, `LCS_OFF_IRQ_ACK)) begin
            rdata_next = link_irq_ack_reg;
        end else if (addr_hit(reg_addr, `LCS_OFF_IRQ_EN)) begin
            rdata_next = link_irq_enable_reg;
        end else if (addr_hit(reg_addr, `LCS_OFF_CYCLE_TIME)) begin
            rdata_next = time_rd;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule // lcs_link_regs
`default_nettype wire

// >>> hw/lcs_map.vh
// Register offsets, field positions, reset values and timing counts of the link control block
`ifndef LCS_MAP_VH
`define LCS_MAP_VH

`define LCS_ADDR_W 12
`define LCS_OFF_LINK_CTRL 12'h004
`define LCS_OFF_IRQ_ACK 12'h008
`define LCS_OFF_IRQ_EN 12'h00c
`define LCS_OFF_CYCLE_TIME 12'h010

`define LCS_CTRL_MASTER_BIT 11
`define LCS_CTRL_EXT_SRC_BIT 10
`define LCS_CTRL_TIMER_RUN_BIT 9
`define LCS_CTRL_XMIT_IDLE_BIT 6
`define LCS_CTRL_ROOT_BIT 5
`define LCS_CTRL_BUSY_PHASE_BIT 4
`define LCS_CTRL_ACK_MSB 3
`define LCS_CTRL_ACK_LSB 0
`define LCS_CTRL_ACK_RESET 4'h2

`define LCS_IRQ_CMD_RESET_BIT 18
`define LCS_IRQ_SUBACTION_GAP_BIT 17
`define LCS_IRQ_ARB_RESET_GAP_BIT 16
`define LCS_IRQ_MASK 32'h0007_0000
`define LCS_IRQ_RESET 32'h0000_0000

`define LCS_CYC_OFFSET_LSB 0
`define LCS_CYC_COUNT_LSB 12
`define LCS_CYC_OFFSET_WRAP 12'd3072
`define LCS_CYC_OFFSET_W 12
`define LCS_CYC_COUNT_W 13
`define LCS_SYNC_STAGES 2

`endif

// >>> hw/lcs_sync.v
// Two-flop synchroniser for asynchronous input pins
`timescale 1ns/1ps
`default_nettype none
module lcs_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire resetn,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    always @(posedge clk) begin
        if (!resetn) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule // lcs_sync
`default_nettype wire

// >>> testbench/lcs_link_regs_checker.sv
// Assertion checker for the link control register bank
`timescale 1ns/1ps
`default_nettype none
module lcs_link_regs_checker #(
    parameter ADDR_W = 12,
    parameter OFFSET_W = 12,
    parameter COUNT_W = 13,
    parameter [OFFSET_W-1:0] OFFSET_WRAP = 12'd8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic link_irq,
    input wire logic cycle_start_req,
    input wire logic [OFFSET_W-1:0] cycle_offset,
    input wire logic [COUNT_W-1:0] cycle_count
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_irq_hold; link_irq && !reg_wr && !$past(reg_wr) |=> link_irq; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq fell without write");
    property p_off_step; ##1 cycle_offset == 0 || cycle_offset == $past(cycle_offset)
        || cycle_offset == $past(cycle_offset) + 1'b1; endproperty
    a_off_step: assert property (p_off_step) else $error("offset jumped");
    property p_off_range; cycle_offset < OFFSET_WRAP; endproperty
    a_off_range: assert property (p_off_range) else $error("offset past wrap");
    property p_cnt_step; cycle_count != $past(cycle_count) |->
        cycle_offset == 0 && cycle_count == $past(cycle_count) + 1'b1; endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("count step bad");
    property p_start_src; cycle_start_req |-> cycle_count != $past(cycle_count)
        || $past(cycle_count) != $past(cycle_count, 2); endproperty
    a_start_src: assert property (p_start_src) else $error("start without count");
    property p_start_pulse; cycle_start_req |=> !cycle_start_req; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start too long");
    property p_ack_rsvd; reg_rd && reg_addr == 12'h008 |=> reg_rdata[15:0] == 16'h0
        && reg_rdata[31:19] == 13'h0; endproperty
    a_ack_rsvd: assert property (p_ack_rsvd) else $error("ack spare bits set");
    property p_ctl_rsvd; reg_rd && reg_addr == 12'h004 |=> reg_rdata[31:12] == 20'h0
        && reg_rdata[8:7] == 2'h0; endproperty
    a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("ctrl spare bits set");
endmodule // lcs_link_regs_checker
bind lcs_link_regs lcs_link_regs_checker #(.ADDR_W(ADDR_W), .OFFSET_W(OFFSET_W),
    .COUNT_W(COUNT_W), .OFFSET_WRAP(OFFSET_WRAP)) u_chk (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_irq(link_irq), .cycle_start_req(cycle_start_req),
    .cycle_offset(cycle_offset), .cycle_count(cycle_count));
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the link control register bank
`timescale 1ns/1ps
`default_nettype none
`include "lcs_map.vh"
module tb;
    logic clk, resetn, reg_wr, reg_rd, pin, idle, sd_done, sd_root, busy, ack_v, irq, st;
    logic [2:0] evt;
    logic [3:0] ack_c, code_m;
    logic [11:0] reg_addr, offs;
    logic [12:0] cnt;
    logic [31:0] reg_wdata, reg_rdata, ctl_m, en_m, ack_m, lfsr;
    logic root_m;
    int err_count, cmp_count, cyc, starts;
    lcs_link_regs #(.OFFSET_WRAP(12'd8)) dut (.clk(clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_cycle_pulse_in(pin), .xmit_idle_in(idle),
        .selfid_done(sd_done), .selfid_root(sd_root), .busy_phase_in(busy),
        .async_ack_valid(ack_v), .async_ack_code(ack_c), .reset_start_write(evt[2]),
        .subaction_gap_seen(evt[1]), .arb_reset_gap_seen(evt[0]), .link_irq(irq),
        .cycle_start_req(st), .cycle_offset(offs), .cycle_count(cnt));
    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] ctl_exp();
        return {20'h0, ctl_m[11:9], 2'b0, idle, root_m, busy, code_m};
    endfunction
    task automatic end_sim();
        $display("comparisons %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (resetn && st)
            starts <= starts + 1;
        if (cyc == 4000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        {resetn, reg_wr, reg_rd, pin, idle, sd_done, sd_root, busy, ack_v} = '0;
        {evt, ack_c, reg_addr, reg_wdata, ctl_m, en_m, ack_m, root_m} = '0;
        code_m = 4'h2;
        lfsr = 32'ha;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        rc(`LCS_OFF_IRQ_ACK, 32'h0);
        rc(`LCS_OFF_LINK_CTRL, ctl_exp());
        for (int i = 0; i < 4; i++) begin
            lfsr = rnd(lfsr);
            root_m = lfsr[2] | (i == 3);
            code_m = lfsr[7:4];
            @(posedge clk);
            {idle, busy, ack_v, sd_done} <= {lfsr[1:0], 2'b11};
            ack_c <= code_m;
            sd_root <= root_m;
            @(posedge clk);
            {ack_v, sd_done, sd_root} <= {2'b00, ~root_m};
            rc(`LCS_OFF_LINK_CTRL, ctl_exp());
        end
        wr(`LCS_OFF_LINK_CTRL, 32'hffff_fbff);
        repeat (19) @(posedge clk);
        wr(`LCS_OFF_LINK_CTRL, 32'h0000_0800);
        ctl_m = 32'h800;
        rc(`LCS_OFF_CYCLE_TIME, {7'h0, 13'd2, 12'd5});
        rc(`LCS_OFF_LINK_CTRL, ctl_exp());
        repeat (10) @(posedge clk);
        rc(`LCS_OFF_CYCLE_TIME, {7'h0, 13'd2, 12'd5});
        chk({7'h0, cnt, offs}, {7'h0, 13'd2, 12'd5});
        wr(`LCS_OFF_LINK_CTRL, 32'h0000_0400);
        ctl_m = 32'h400;
        repeat (3) begin
            @(posedge clk);
            pin <= 1'b1;
            repeat (5) @(posedge clk);
            pin <= 1'b0;
            repeat (5) @(posedge clk);
        end
        rc(`LCS_OFF_CYCLE_TIME, {7'h0, 13'd5, 12'd0});
        chk({7'h0, cnt, offs}, {7'h0, 13'd5, 12'd0});
        chk(starts, 2);
        wr(`LCS_OFF_IRQ_EN, 32'hffff_ffff);
        en_m = `LCS_IRQ_MASK;
        rc(`LCS_OFF_IRQ_EN, en_m);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            evt[k] <= 1'b1;
            @(posedge clk);
            evt[k] <= 1'b0;
            #1;
            ack_m[16+k] = 1'b1;
            chk(irq, 1'b1);
            rc(`LCS_OFF_IRQ_ACK, ack_m);
        end
        wr(12'h020, 32'hffff_ffff);
        rc(12'h020, 32'h0);
        wr(`LCS_OFF_IRQ_ACK, 32'h0);
        rc(`LCS_OFF_IRQ_ACK, ack_m);
        for (int i = 0; i < 8; i++) begin
            lfsr = rnd(lfsr);
            wr(`LCS_OFF_IRQ_ACK, {lfsr[15:0], lfsr[31:16]});
            ack_m &= ~{lfsr[15:0], lfsr[31:16]};
            rc(`LCS_OFF_IRQ_ACK, ack_m);
            wr(`LCS_OFF_IRQ_EN, {lfsr[18:0], lfsr[31:19]});
            en_m = {lfsr[18:0], lfsr[31:19]} & `LCS_IRQ_MASK;
            @(posedge clk);
            evt <= lfsr[10:8];
            @(posedge clk);
            evt <= 3'b0;
            ack_m |= {13'h0, lfsr[10:8], 16'h0};
            rc(`LCS_OFF_IRQ_ACK, ack_m);
            chk(irq, |(ack_m & en_m));
        end
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rc(`LCS_OFF_IRQ_ACK, 32'h0);
        rc(`LCS_OFF_IRQ_EN, 32'h0);
        chk(irq, 1'b0);
        end_sim();
    end
endmodule // tb
`default_nettype wire
